// ### logic/sar_readout_pkg.sv
// Constants and types shared by the converter control and readout logic.
package sar_readout_pkg;
  // Core clock period in picoseconds (50 MHz).
  localparam int CLK_PERIOD_PS = 20000;
  // Conversion duration used by the internal sequencer, in ns.
  localparam int CONV_TIME_NS = 360;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Longest permitted busy-high interval, in ns (rounded down to cycles).
  localparam int BUSY_MAX_NS = 370;
  localparam int BUSY_MAX_CYCLES = (BUSY_MAX_NS * 1000) / CLK_PERIOD_PS;
  // Abort window bounds after the start edge, in ns.
  localparam int ABORT_MIN_NS = 70;
  localparam int ABORT_MAX_NS = 350;
  localparam int ABORT_MIN_CYCLES = (ABORT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ABORT_MAX_CYCLES = (ABORT_MAX_NS * 1000) / CLK_PERIOD_PS;
  // Result and bus widths.
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] FOLD_FILL = 8'hFF;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  // Sequencer states.
  typedef enum logic [1:0] {ST_ACQUIRE, ST_CONVERT, ST_DONE} conv_state_t;
endpackage : sar_readout_pkg

// ### logic/sar_adc_parallel_readout_control.sv
// Conversion sequencer and parallel result readout of a 16-bit SAR converter.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_readout_control
  import sar_readout_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Host control pins.
  input wire logic convert_strobe_n,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic byte_select,
  // Status and data bus.
  output logic busy,
  output logic [15:0] output_bus,
  output logic [15:0] output_bus_oe,
  // Sampled code from the analog core with its handshake.
  input wire logic [15:0] sar_code,
  input wire logic sar_valid,
  output logic sar_ready
);

  ////////////////////////////////////////////////////////////////////////
  conv_state_t state;
  logic [8:0] conv_cnt;
  logic strobe_q;
  logic select_q;
  logic strobe_fall;
  logic select_fall;
  logic abort_hit;
  logic acq_armed;
  logic [15:0] result;
  // Two-entry buffer between the analog core and the result latch.
  logic [15:0] buf_mem [2];
  logic buf_wr;
  logic buf_rd;
  logic [1:0] buf_count;
  logic buf_wp;
  logic buf_rp;
  logic buf_out_valid;
  logic buf_out_ready;

  // Edge history of the strobe and select pins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b1;
      select_q <= 1'b1;
    end else begin
      strobe_q <= convert_strobe_n;
      select_q <= select_n;
    end
  end

  assign strobe_fall = strobe_q && !convert_strobe_n;
  assign select_fall = select_q && !select_n;

  assign abort_hit = (state == ST_CONVERT) &&
                     (conv_cnt >= 9'(ABORT_MIN_CYCLES)) &&
                     (conv_cnt <= 9'(ABORT_MAX_CYCLES)) &&
                     ((strobe_fall && !select_n) || select_fall);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acq_armed <= 1'b1;
    end else if (state == ST_CONVERT) begin
      // A select-edge abort is itself the start of a new acquisition.
      acq_armed <= abort_hit && select_fall;
    end else if (select_fall || state == ST_DONE) begin
      acq_armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer on the core clock only.
  // asynchronous reset ends conversion at once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_ACQUIRE;
      conv_cnt <= CNT_ZERO;
    end else begin
      unique case (state)
        ST_ACQUIRE: begin
          conv_cnt <= CNT_ZERO;
          if (strobe_fall && !select_n && acq_armed) begin
            state <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          conv_cnt <= conv_cnt + 9'h001;
          if (abort_hit) begin
            state <= ST_ACQUIRE;
          end else if (conv_cnt == 9'(CONV_CYCLES - 1) && buf_out_valid) begin
            state <= ST_DONE;
          end else if (conv_cnt == 9'(BUSY_MAX_CYCLES - 1)) begin
            state <= ST_ACQUIRE;
          end
        end
        ST_DONE: begin
          state <= ST_ACQUIRE;
        end
      endcase
    end
  end

  // busy rises one cycle after the edge.
  // busy falls at the end cycle.
  assign busy = (state == ST_CONVERT);

  ////////////////////////////////////////////////////////////////////////
  // Buffer writes when a code arrives and a slot is free.
  assign sar_ready = (buf_count != 2'd2);
  assign buf_wr = sar_valid && sar_ready;
  assign buf_out_valid = (buf_count != 2'd0);
  assign buf_out_ready = (state == ST_DONE);
  assign buf_rd = buf_out_valid && buf_out_ready;

  // Buffer pointers and occupancy count.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_count <= 2'd0;
    end else begin
      if (buf_wr) begin
        buf_wp <= !buf_wp;
      end
      if (buf_rd) begin
        buf_rp <= !buf_rp;
      end
      buf_count <= buf_count + 2'(buf_wr) - 2'(buf_rd);
    end
  end

  // Buffer data array, no reset needed.
  always_ff @(posedge core_clk) begin
    if (buf_wr) begin
      buf_mem[buf_wp] <= sar_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // atomic latch of all sixteen bits.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result <= RESULT_RESET;
    end else if (buf_rd) begin
      result <= buf_mem[buf_rp];
    end
  end

  // drive bus only on select and read.
  // result visible the cycle after end.
  always_comb begin
    output_bus_oe = {RESULT_W{!select_n && !read_n}};
    if (byte_select) begin
      output_bus = {result[BYTE_W-1:0], FOLD_FILL};
    end else begin
      output_bus = result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy-high interval length counter for checking.
  logic [8:0] busy_len;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_len <= CNT_ZERO;
    end else if (busy) begin
      busy_len <= busy_len + 9'h001;
    end else begin
      busy_len <= CNT_ZERO;
    end
  end

  chk_busy_rise: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_ACQUIRE && strobe_fall && !select_n && acq_armed) |=> busy)
    else $error("Busy did not rise after the start strobe.");
  chk_busy_bound: assert property (@(posedge core_clk) disable iff (rst)
    busy_len <= 9'(BUSY_MAX_CYCLES))
    else $error("Busy stayed high too long.");
  chk_abort_drops: assert property (@(posedge core_clk) disable iff (rst)
    abort_hit |=> !busy && $stable(result))
    else $error("Abort did not drop busy or changed the result.");
  chk_result_hold: assert property (@(posedge core_clk) disable iff (rst)
    busy |=> (busy || state == ST_DONE || $stable(result)))
    else $error("Result changed during conversion.");
  chk_result_latch: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_DONE) |=> (result == $past(buf_mem[buf_rp])))
    else $error("Result was not latched at end of conversion.");
  chk_bus_enable: assert property (@(posedge core_clk) disable iff (rst)
    (output_bus_oe == 16'hFFFF) == (!select_n && !read_n))
    else $error("Bus enable does not follow select and read.");
  chk_byte_fold: assert property (@(posedge core_clk) disable iff (rst)
    byte_select |-> output_bus == {result[7:0], 8'hFF})
    else $error("Byte fold output is wrong.");
  chk_done_time: assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy) |-> ##[1:19] !busy)
    else $error("Conversion exceeded its time.");
  chk_busy_state: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_DONE) |-> $fell(busy))
    else $error("Busy not low at end of conversion.");
  chk_select_rearm: assert property (@(posedge core_clk) disable iff (rst)
    (abort_hit && select_fall) |=> acq_armed)
    else $error("Select abort did not start a new acquisition.");

  cov_full_conv: cover property (@(posedge core_clk) disable iff (rst)
    state == ST_DONE);
  cov_abort: cover property (@(posedge core_clk) disable iff (rst) abort_hit);
  cov_byte_read: cover property (@(posedge core_clk) disable iff (rst)
    output_bus_oe[0] && byte_select);

endmodule : sar_adc_parallel_readout_control
`default_nettype wire

// ### sim/sar_core_model.sv
// Behavioural analog core that offers codes to the converter's buffer.
`timescale 1ns/1ps
`default_nettype none
module sar_core_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Buffer handshake and stall request.
  input wire logic sar_ready,
  input wire logic stall,
  output logic [15:0] sar_code,
  output logic sar_valid
);
  logic took;
  logic in_rst;
  // Holds each code until taken; an idle bus toggles so stale data never looks valid.
  initial begin
    void'($urandom(3));
    sar_code = 16'h0000;
    sar_valid = 1'b0;
    forever begin
      @(posedge core_clk);
      took = sar_valid && sar_ready;
      in_rst = rst;
      #1;
      if (in_rst || ((!sar_valid || took) && (stall || $urandom % 4 == 0))) begin
        sar_valid = 1'b0;
        sar_code = ~sar_code;
      end else if (!sar_valid || took) begin
        sar_valid = 1'b1;
        sar_code = 16'($urandom);
      end
    end
  end
endmodule : sar_core_model
`default_nettype wire

// ### sim/sar_adc_parallel_readout_control_test.sv
// Self-checking bench for the converter sequencer and parallel readout.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_readout_control_test;
  import sar_readout_pkg::*;
  logic core_clk = 0, rst = 1, convert_strobe_n = 1, select_n = 1, read_n = 1;
  logic byte_select = 0, stall = 0, busy, sar_valid, sar_ready;
  logic [15:0] output_bus, output_bus_oe, sar_code, exp_word;
  logic [15:0] codes[$];
  int n_mismatch = 0, samples_checked = 0, nb, nq;
  initial forever #10 core_clk = ~core_clk;
  sar_adc_parallel_readout_control u_dut (.core_clk(core_clk), .rst(rst),
    .convert_strobe_n(convert_strobe_n), .select_n(select_n), .read_n(read_n),
    .byte_select(byte_select), .busy(busy), .output_bus(output_bus),
    .output_bus_oe(output_bus_oe), .sar_code(sar_code), .sar_valid(sar_valid),
    .sar_ready(sar_ready));
  sar_core_model u_core (.core_clk(core_clk), .rst(rst), .sar_ready(sar_ready),
    .stall(stall), .sar_code(sar_code), .sar_valid(sar_valid));
  // Reference buffer: every accepted code in arrival order.
  always @(posedge core_clk) if (!rst && sar_valid && sar_ready) codes.push_back(sar_code);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // select falls, acquisition, then a one-cycle strobe.
  task start;
    select_n = 1;
    tick(2);
    select_n = 0;
    tick(6);
    convert_strobe_n = 0;
    tick(1);
    convert_strobe_n = 1;
  endtask : start
  task convert(input int abort_at);
    start();
    if (abort_at > 0) begin
      tick(abort_at);
      // abort by strobe, or by select when odd.
      if (abort_at % 2) select_n = 1;
      else convert_strobe_n = 0;
      tick(1);
      select_n = 0;
      convert_strobe_n = 1;
      tick(2);
      chk(busy, 0);
    end else begin
      nb = 0;
      nq = 0;
      while (busy === 1'b1 && nb < 40) begin
        nb++;
        if (nb == CONV_CYCLES) nq = codes.size();
        read_n = (nb < 3 || nb > 10);
        if (nb == 6) chk(output_bus, exp_word);
        tick(1);
      end
      chk(nb >= 17 && nb <= BUSY_MAX_CYCLES, 1);
      if (nq > 0) exp_word = codes.pop_front();
    end
    tick(2);
    read_n = 0;
    tick(1);
    chk(output_bus_oe, 16'hFFFF);
    chk(output_bus, exp_word);
    // byte changes spaced, read held low.
    byte_select = 1;
    tick(3);
    chk(output_bus, {exp_word[7:0], FOLD_FILL});
    byte_select = 0;
    tick(3);
    read_n = 1;
    tick(1);
    chk(output_bus_oe, 16'h0000);
  endtask : convert
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under ten thousand cycles.
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  // Main sequence: full runs, abort, drained buffer, reset mid-conversion.
  initial begin
    exp_word = RESULT_RESET;
    tick(4);
    rst = 0;
    tick(10);
    chk(sar_ready, 0);
    for (int i = 0; i < 4; i++) convert(0);
    convert(6);
    convert(7);
    stall = 1;
    repeat (4) convert(0);
    chk(sar_ready, 1);
    stall = 0;
    start();
    tick(5);
    rst = 1;
    read_n = 0;
    tick(3);
    chk(busy, 0);
    chk(output_bus, RESULT_RESET);
    rst = 0;
    read_n = 1;
    codes.delete();
    exp_word = RESULT_RESET;
    tick(10);
    convert(0);
    wrap_up();
  end
endmodule : sar_adc_parallel_readout_control_test
`default_nettype wire
